// [hw/rsc_pkg.sv]
// Constants and types shared by the reset source controller files
package rsc_pkg;
	// Timing
	localparam int CLK_PERIOD_NS     = 50;
	localparam int MCD_TIME_NS       = 100000;
	localparam int MCD_CYCLES        = (MCD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WDT_DIV           = 12;
	localparam int WDT_TIMEOUT_TICKS = 256;
	localparam int RESET_HOLD_CYCLES = 16;

	// Register map: cause register index as printed, byte address is four times it
	localparam logic [11:0] CAUSE_INDEX = 12'h0EF;
	localparam logic [11:0] CAUSE_ADDR  = {CAUSE_INDEX[9:0], 2'b00};
	localparam logic [11:0] CTRL_INDEX  = 12'h0F0;
	localparam logic [11:0] CTRL_ADDR   = {CTRL_INDEX[9:0], 2'b00};

	// Cause register fields
	localparam int PIN_BIT   = 0;
	localparam int POR_BIT   = 1;
	localparam int MCD_BIT   = 2;
	localparam int WDT_BIT   = 3;
	localparam int SW_BIT    = 4;
	localparam int CMP_BIT   = 5;
	localparam int FLASH_BIT = 6;
	localparam int RTC_BIT   = 7;

	// Control register fields
	localparam int CTRL_WDT_EN_BIT    = 0;
	localparam int CTRL_KICK_BIT      = 1;
	localparam int CTRL_IN_RESET_BIT  = 2;
	localparam int CTRL_LOW_POWER_BIT = 3;
	localparam int CTRL_SUPPLY_EN_BIT = 4;
	localparam int CTRL_MCD_EN_BIT    = 5;
	localparam int CTRL_CMP_EN_BIT    = 6;
	localparam int CTRL_RTC_EN_BIT    = 7;

	// Reset values
	localparam logic [7:0] FLAGS_RESET     = 8'h02;
	localparam logic       SUPPLY_EN_RESET = 1'b1;
	localparam logic       MCD_EN_RESET    = 1'b0;
	localparam logic       CMP_EN_RESET    = 1'b0;
	localparam logic       RTC_EN_RESET    = 1'b0;
	localparam logic       WDT_EN_RESET    = 1'b1;

	// Bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b01,
		ST_HOLD = 2'b10
	} rsc_state_t;
endpackage : rsc_pkg

// [hw/rsc_wdt_if.sv]
// Link between the reset sequencer and the watchdog
`timescale 1ns/1ps
interface rsc_wdt_if;
	logic enable;
	logic kick;
	logic hold;
	logic timeout;

	modport ctrl (output enable, output kick, output hold, input timeout);
	modport wdt  (input enable, input kick, input hold, output timeout);
endinterface : rsc_wdt_if

// [hw/rsc_watchdog.sv]
// Watchdog timer clocked by a divided enable pulse
`timescale 1ns/1ps
module rsc_watchdog #(
	parameter int DIV   = rsc_pkg::WDT_DIV,
	parameter int TICKS = rsc_pkg::WDT_TIMEOUT_TICKS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Sequencer link
	rsc_wdt_if.wdt   link
);
	localparam int DW = $clog2(DIV);
	localparam int TW = $clog2(TICKS);

	typedef struct packed {
		logic [DW-1:0] div_cnt;
		logic [TW-1:0] tick_cnt;
		logic          timeout;
	} rsc_wdt_state_t;

	rsc_wdt_state_t s;
	rsc_wdt_state_t next_s;

	always_comb begin
		next_s = s;
		next_s.timeout = 1'b0;
		if (link.hold) begin
			next_s.div_cnt = '0;
			next_s.tick_cnt = '0;
		end else if (link.kick) begin
			next_s.tick_cnt = '0;
		end else if (link.enable) begin
			// Counting pauses while disabled, so low power only suspends it
			if (s.div_cnt == DW'(DIV - 1)) begin
				next_s.div_cnt = '0;
				if (s.tick_cnt == TW'(TICKS - 1)) begin
					next_s.tick_cnt = '0;
					next_s.timeout = 1'b1;
				end else begin
					next_s.tick_cnt = s.tick_cnt + 1'b1;
				end
			end else begin
				next_s.div_cnt = s.div_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign link.timeout = s.timeout;
endmodule : rsc_watchdog

// [hw/rsc_top.sv]
// Reset source controller: cause logging, enables and system reset sequencing
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module rsc_top #(
	parameter int ADDR_W   = 12,
	parameter int FLASH_AW = 17,
	parameter int RTC_W    = 32,
	parameter int HOLD     = rsc_pkg::RESET_HOLD_CYCLES,
	parameter int WDT_DIV  = rsc_pkg::WDT_DIV,
	parameter int WDT_TICKS = rsc_pkg::WDT_TIMEOUT_TICKS
) (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RESET_N,
	// AXI4-Lite write address
	input  wire logic                AWVALID,
	output wire logic                AWREADY,
	input  wire logic [ADDR_W-1:0]   AWADDR,
	input  wire logic [2:0]          AWPROT,
	// AXI4-Lite write data
	input  wire logic                WVALID,
	output wire logic                WREADY,
	input  wire logic [31:0]         WDATA,
	input  wire logic [3:0]          WSTRB,
	// AXI4-Lite write response
	output wire logic                BVALID,
	input  wire logic                BREADY,
	output wire logic [1:0]          BRESP,
	// AXI4-Lite read address
	input  wire logic                ARVALID,
	output wire logic                ARREADY,
	input  wire logic [ADDR_W-1:0]   ARADDR,
	input  wire logic [2:0]          ARPROT,
	// AXI4-Lite read data
	output wire logic                RVALID,
	input  wire logic                RREADY,
	output wire logic [31:0]         RDATA,
	output wire logic [1:0]          RRESP,
	// Reset sources
	input  wire logic                RST_PIN_N,
	input  wire logic                POWER_ON_EVENT,
	input  wire logic                SUPPLY_LOW,
	input  wire logic                SYSTEM_CLOCK_SENSE,
	input  wire logic                COMP_PLUS_BELOW_MINUS,
	input  wire logic                COMP_WAKE_EN,
	// Power state
	input  wire logic                SUSPEND,
	input  wire logic                SLEEP,
	// Flash access monitor
	input  wire logic [FLASH_AW-1:0] FLASH_ADDR,
	input  wire logic [FLASH_AW-1:0] FLASH_LOCK_ADDR,
	input  wire logic                FLASH_WRITE_ENABLE,
	input  wire logic                FLASH_WRITE_ERASE,
	input  wire logic                FLASH_CODE_READ,
	input  wire logic                FLASH_FETCH,
	input  wire logic                FLASH_SECURITY_BLOCK,
	input  wire logic                SUPPLY_MONITOR_ON,
	// Real-time clock
	input  wire logic                RTC_CLKMON_EN,
	input  wire logic                RTC_CLOCK_SLOW,
	input  wire logic                RTC_ALARM_EN,
	input  wire logic [RTC_W-1:0]    RTC_TIMER,
	input  wire logic [RTC_W-1:0]    RTC_ALARM_VALUE,
	// System reset
	output wire logic                SYS_RESET
);
	localparam int HW = $clog2(HOLD + 1);
	localparam int MW = $clog2(rsc_pkg::MCD_CYCLES + 1);

	typedef struct packed {
		rsc_pkg::rsc_state_t state;
		logic [HW-1:0]       hold_cnt;
		logic [7:0]          flags;
		logic                supply_en;
		logic                mcd_en;
		logic                cmp_en;
		logic                rtc_en;
		logic                wdt_en;
		logic                kick;
		logic                soft_req;
		logic                sense_q;
		logic [MW-1:0]       mcd_cnt;
		logic                sys_reset;
		logic                awready;
		logic [ADDR_W-1:0]   awaddr;
		logic                aw_full;
		logic                wready;
		logic [31:0]         wdata;
		logic [3:0]          wstrb;
		logic                w_full;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
	} rsc_top_state_t;

	rsc_top_state_t s;
	rsc_top_state_t next_s;

	rsc_wdt_if wdt_link ();

	logic       low_power;
	logic       flash_above;
	logic       flash_fault;
	logic [7:0] cause;
	logic [7:0] first_cause;

	assign low_power = SUSPEND | SLEEP;
	assign flash_above = FLASH_ADDR > FLASH_LOCK_ADDR;

	// Illegal flash accesses
	assign flash_fault = (FLASH_WRITE_ENABLE & FLASH_WRITE_ERASE & flash_above)
		| (FLASH_CODE_READ & flash_above)
		| (FLASH_FETCH & flash_above)
		| FLASH_SECURITY_BLOCK
		| (FLASH_WRITE_ERASE & ~SUPPLY_MONITOR_ON);

	// Live reset requests, one per flag position
	always_comb begin
		cause = 8'h00;
		cause[rsc_pkg::PIN_BIT] = ~RST_PIN_N;
		cause[rsc_pkg::POR_BIT] = POWER_ON_EVENT | (s.supply_en & SUPPLY_LOW);
		cause[rsc_pkg::MCD_BIT] = s.mcd_en & ~low_power
			& (s.mcd_cnt == MW'(rsc_pkg::MCD_CYCLES));
		cause[rsc_pkg::WDT_BIT] = wdt_link.timeout;
		cause[rsc_pkg::SW_BIT] = s.soft_req;
		cause[rsc_pkg::CMP_BIT] = s.cmp_en & (~low_power | COMP_WAKE_EN)
			& COMP_PLUS_BELOW_MINUS;
		cause[rsc_pkg::FLASH_BIT] = flash_fault;
		cause[rsc_pkg::RTC_BIT] = s.rtc_en
			& ((RTC_CLKMON_EN & RTC_CLOCK_SLOW)
			| (RTC_ALARM_EN & (RTC_TIMER == RTC_ALARM_VALUE)));
	end

	// Lowest bit wins: pin, then power-on, then the internal sources
	assign first_cause = cause & (~cause + 8'h01);

	always_comb begin
		next_s = s;
		next_s.kick = 1'b0;

		// Clock loss detector: cycles since the sensed clock last changed
		next_s.sense_q = SYSTEM_CLOCK_SENSE;
		if (!s.mcd_en || low_power || s.state != rsc_pkg::ST_RUN
			|| SYSTEM_CLOCK_SENSE != s.sense_q) begin
			next_s.mcd_cnt = '0;
		end else if (s.mcd_cnt != MW'(rsc_pkg::MCD_CYCLES)) begin
			next_s.mcd_cnt = s.mcd_cnt + 1'b1;
		end

		// Write address and data are taken independently
		if (s.awready && AWVALID) begin
			next_s.awaddr = AWADDR;
			next_s.aw_full = 1'b1;
			next_s.awready = 1'b0;
		end
		if (s.wready && WVALID) begin
			next_s.wdata = WDATA;
			next_s.wstrb = WSTRB;
			next_s.w_full = 1'b1;
			next_s.wready = 1'b0;
		end
		if (s.bvalid && BREADY) begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		if (s.aw_full && s.w_full && !s.bvalid) begin
			next_s.aw_full = 1'b0;
			next_s.w_full = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = rsc_pkg::RESP_OKAY;
			if (s.awaddr == rsc_pkg::CAUSE_ADDR) begin
				// Only enable bits and the force bit act; flag bits are dropped
				if (s.wstrb[0]) begin
					next_s.supply_en = s.wdata[rsc_pkg::POR_BIT];
					next_s.mcd_en = s.wdata[rsc_pkg::MCD_BIT];
					next_s.cmp_en = s.wdata[rsc_pkg::CMP_BIT];
					next_s.rtc_en = s.wdata[rsc_pkg::RTC_BIT];
					next_s.soft_req = s.wdata[rsc_pkg::SW_BIT];
				end
			end else if (s.awaddr == rsc_pkg::CTRL_ADDR) begin
				if (s.wstrb[0]) begin
					next_s.wdt_en = s.wdata[rsc_pkg::CTRL_WDT_EN_BIT];
					next_s.kick = s.wdata[rsc_pkg::CTRL_KICK_BIT];
				end
			end else begin
				next_s.bresp = rsc_pkg::RESP_SLVERR;
			end
		end

		// Read channel
		if (s.rvalid && RREADY) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
		if (s.arready && ARVALID) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = 32'h00000000;
			next_s.rresp = rsc_pkg::RESP_OKAY;
			if (ARADDR == rsc_pkg::CAUSE_ADDR) begin
				next_s.rdata[7:0] = s.flags;
			end else if (ARADDR == rsc_pkg::CTRL_ADDR) begin
				next_s.rdata[rsc_pkg::CTRL_WDT_EN_BIT] = s.wdt_en;
				next_s.rdata[rsc_pkg::CTRL_IN_RESET_BIT] = s.sys_reset;
				next_s.rdata[rsc_pkg::CTRL_LOW_POWER_BIT] = low_power;
				next_s.rdata[rsc_pkg::CTRL_SUPPLY_EN_BIT] = s.supply_en;
				next_s.rdata[rsc_pkg::CTRL_MCD_EN_BIT] = s.mcd_en;
				next_s.rdata[rsc_pkg::CTRL_CMP_EN_BIT] = s.cmp_en;
				next_s.rdata[rsc_pkg::CTRL_RTC_EN_BIT] = s.rtc_en;
			end else begin
				next_s.rresp = rsc_pkg::RESP_SLVERR;
			end
		end

		// Reset sequencer; the external pin is only ever an input here
		case (s.state)
			rsc_pkg::ST_RUN: begin
				if (cause != 8'h00) begin
					next_s.state = rsc_pkg::ST_HOLD;
					next_s.flags = first_cause;
					next_s.hold_cnt = '0;
					next_s.sys_reset = 1'b1;
					next_s.soft_req = 1'b0;
					next_s.wdt_en = 1'b1;
				end
			end
			rsc_pkg::ST_HOLD: begin
				next_s.soft_req = 1'b0;
				next_s.wdt_en = 1'b1;
				// Pin and power-on stretch the reset until they release
				if (!RST_PIN_N || POWER_ON_EVENT) begin
					next_s.hold_cnt = '0;
				end else if (s.hold_cnt == HW'(HOLD - 1)) begin
					next_s.state = rsc_pkg::ST_RUN;
					next_s.sys_reset = 1'b0;
				end else begin
					next_s.hold_cnt = s.hold_cnt + 1'b1;
				end
			end
			default: begin
				next_s.state = rsc_pkg::ST_HOLD;
				next_s.hold_cnt = '0;
				next_s.sys_reset = 1'b1;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s <= '0;
			s.state <= rsc_pkg::ST_HOLD;
			s.flags <= rsc_pkg::FLAGS_RESET;
			s.supply_en <= rsc_pkg::SUPPLY_EN_RESET;
			s.mcd_en <= rsc_pkg::MCD_EN_RESET;
			s.cmp_en <= rsc_pkg::CMP_EN_RESET;
			s.rtc_en <= rsc_pkg::RTC_EN_RESET;
			s.wdt_en <= rsc_pkg::WDT_EN_RESET;
			s.sys_reset <= 1'b1;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Watchdog link: counting stops in low power and clears during reset
	assign wdt_link.enable = s.wdt_en & ~low_power;
	assign wdt_link.kick = s.kick;
	assign wdt_link.hold = s.sys_reset;

	rsc_watchdog #(
		.DIV   (WDT_DIV),
		.TICKS (WDT_TICKS)
	) u_watchdog (
		.clk     (CLK),
		.reset_n (RESET_N),
		.link    (wdt_link)
	);

	assign AWREADY = s.awready;
	assign WREADY = s.wready;
	assign BVALID = s.bvalid;
	assign BRESP = s.bresp;
	assign ARREADY = s.arready;
	assign RVALID = s.rvalid;
	assign RDATA = s.rdata;
	assign RRESP = s.rresp;
	assign SYS_RESET = s.sys_reset;
endmodule : rsc_top

// [verif/rsc_top_assertions.sv]
// Port-level checks of the reset source controller
`timescale 1ns/1ps
module rsc_top_assertions (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Bus handshakes
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic RREADY,
	// Reset sources and output
	input wire logic RST_PIN_N,
	input wire logic POWER_ON_EVENT,
	input wire logic SYS_RESET
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	property p_wr;
		AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY && !WREADY ##1 BVALID;
	endproperty
	a_wr: assert property (p_wr) else $error("write answer wrong");
	property p_bdone;
		BVALID && BREADY |=> !BVALID && AWREADY && WREADY;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write close wrong");
	property p_rd;
		ARVALID && ARREADY |=> RVALID && !ARREADY;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer wrong");
	property p_rdone;
		RVALID && RREADY |=> !RVALID && ARREADY;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read close wrong");
	property p_pin;
		!RST_PIN_N |=> SYS_RESET;
	endproperty
	a_pin: assert property (p_pin) else $error("pin did not reset");
	property p_por;
		POWER_ON_EVENT |=> SYS_RESET;
	endproperty
	a_por: assert property (p_por) else $error("power-on did not reset");
	property p_rose;
		$rose(SYS_RESET) |=> SYS_RESET;
	endproperty
	a_rose: assert property (p_rose) else $error("reset pulse too short");
	property p_fell;
		$fell(SYS_RESET) |-> $past(RST_PIN_N, 2) && !$past(POWER_ON_EVENT, 2);
	endproperty
	a_fell: assert property (p_fell) else $error("reset ended too early");
endmodule : rsc_top_assertions

bind rsc_top rsc_top_assertions u_chk (.CLK, .RESET_N, .AWVALID, .AWREADY, .WVALID, .WREADY,
	.BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .RREADY, .RST_PIN_N, .POWER_ON_EVENT,
	.SYS_RESET);

// [verif/rsc_top_tb.sv]
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
module rsc_top_tb;
	localparam logic [11:0] CA = rsc_pkg::CAUSE_ADDR;
	localparam logic [11:0] CT = rsc_pkg::CTRL_ADDR;
	logic        CLK = 0, RESET_N = 0, RST_PIN_N = 1, POWER_ON_EVENT = 0, SUPPLY_LOW = 0;
	logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, SYS_RESET;
	logic [1:0]  BRESP, RRESP, r, br;
	logic [11:0] AWADDR = 0, ARADDR = 0;
	logic [31:0] WDATA = 0, RDATA, d, v, RTC_TIMER = 0, RTC_ALARM_VALUE = 0;
	logic [16:0] FLASH_ADDR = 0, FLASH_LOCK_ADDR = 0;
	logic        SYSTEM_CLOCK_SENSE = 0, COMP_PLUS_BELOW_MINUS = 0, COMP_WAKE_EN = 0;
	logic        SUSPEND = 0, SLEEP = 0, FLASH_WRITE_ENABLE = 0, FLASH_WRITE_ERASE = 0;
	logic        FLASH_CODE_READ = 0, FLASH_FETCH = 0, FLASH_SECURITY_BLOCK = 0;
	logic        SUPPLY_MONITOR_ON = 1, RTC_CLKMON_EN = 0, RTC_CLOCK_SLOW = 0, RTC_ALARM_EN = 0;
	logic        sense_run = 1;
	int          seed = 44332, n_mismatch = 0, comparisons = 0, cyc = 0, lat;

	rsc_top #(.HOLD(4)) uut (.CLK, .RESET_N, .AWVALID, .AWREADY, .AWADDR, .AWPROT(3'h0),
		.WVALID, .WREADY, .WDATA, .WSTRB(4'hF), .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
		.ARADDR, .ARPROT(3'h0), .RVALID, .RREADY, .RDATA, .RRESP, .RST_PIN_N, .POWER_ON_EVENT,
		.SUPPLY_LOW, .SYSTEM_CLOCK_SENSE, .COMP_PLUS_BELOW_MINUS, .COMP_WAKE_EN, .SUSPEND, .SLEEP,
		.FLASH_ADDR, .FLASH_LOCK_ADDR, .FLASH_WRITE_ENABLE, .FLASH_WRITE_ERASE, .FLASH_CODE_READ,
		.FLASH_FETCH, .FLASH_SECURITY_BLOCK, .SUPPLY_MONITOR_ON, .RTC_CLKMON_EN, .RTC_CLOCK_SLOW,
		.RTC_ALARM_EN, .RTC_TIMER, .RTC_ALARM_VALUE, .SYS_RESET);

	always #25 CLK = ~CLK;
	// Watched clock toggles unless a test stops it
	always @(posedge CLK) begin
		SYSTEM_CLOCK_SENSE <= sense_run ? ~SYSTEM_CLOCK_SENSE : SYSTEM_CLOCK_SENSE;
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	task close_out;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// Expected cause register value: only the flag of the causing source
	function automatic logic [7:0] flag_of(input int b);
		return 8'h01 << b;
	endfunction : flag_of

	task wr(input logic [11:0] a, input logic [31:0] x);
		logic p, q;
		@(posedge CLK);
		p = 1;
		q = 1;
		AWADDR <= a;
		WDATA <= x;
		AWVALID <= 1;
		WVALID <= 1;
		BREADY <= 1;
		while (p || q) begin
			@(posedge CLK);
			p = p && !AWREADY;
			q = q && !WREADY;
			AWVALID <= p;
			WVALID <= q;
		end
		while (!BVALID) @(posedge CLK);
		br = BRESP;
		BREADY <= 0;
	endtask : wr

	task rd(input logic [11:0] a);
		@(posedge CLK);
		ARADDR <= a;
		ARVALID <= 1;
		RREADY <= 1;
		do @(posedge CLK); while (!ARREADY);
		ARVALID <= 0;
		while (!RVALID) @(posedge CLK);
		d = RDATA;
		r = RRESP;
		RREADY <= 0;
	endtask : rd

	task idle;
		{RST_PIN_N, POWER_ON_EVENT, SUPPLY_LOW, COMP_PLUS_BELOW_MINUS} <= 4'h8;
		{SUSPEND, SLEEP, FLASH_SECURITY_BLOCK, SUPPLY_MONITOR_ON} <= 4'h1;
		{FLASH_WRITE_ENABLE, FLASH_WRITE_ERASE, FLASH_CODE_READ, FLASH_FETCH} <= 4'h0;
		{RTC_CLKMON_EN, RTC_CLOCK_SLOW, RTC_ALARM_EN} <= 3'h0;
		sense_run = 1;
	endtask : idle

	// Waits for the system reset, drops all sources, then reads the logged cause
	task trig(input logic [7:0] e, input int lim);
		lat = 0;
		while (SYS_RESET !== 1'b1 && lat < lim) begin
			@(posedge CLK);
			lat++;
		end
		chk("sys_reset", SYS_RESET, 1);
		idle();
		while (SYS_RESET !== 1'b0) @(posedge CLK);
		rd(CA);
		chk("cause", d, {24'h0, e});
	endtask : trig

	initial begin
		repeat (3) @(posedge CLK);
		RESET_N <= 1;
		while (SYS_RESET !== 1'b0) @(posedge CLK);
		rd(CA);
		chk("por_flag", d, 32'h02);
		rd(CT);
		chk("ctrl", d, 32'h11);
		rd(12'h100);
		chk("unmapped", {d[29:0], r}, 32'h2);
		wr(12'h104, 32'hFF);
		chk("unmapped_b", br, 2'h2);
		wr(CA, 32'h4B);
		rd(CA);
		chk("ro_cause", d, 32'h02);
		wr(CA, 32'hE6);
		rd(CT);
		chk("enables", d, 32'hF1);
		wr(CA, 32'h02);
		rd(CT);
		chk("disable", d, 32'h11);
		$display("test registers done");
		wr(CA, 32'h12);
		trig(8'h10, 10);
		RST_PIN_N <= 0;
		trig(8'h01, 5);
		SLEEP <= 1;
		RST_PIN_N <= 0;
		trig(8'h01, 5);
		POWER_ON_EVENT <= 1;
		trig(8'h02, 5);
		wr(CA, 32'h02);
		SUPPLY_LOW <= 1;
		trig(8'h02, 5);
		wr(CA, 32'h22);
		SUSPEND <= 1;
		COMP_PLUS_BELOW_MINUS <= 1;
		repeat (40) @(posedge CLK);
		chk("cmp_asleep", SYS_RESET, 0);
		COMP_WAKE_EN <= 1;
		trig(8'h20, 5);
		$display("test pins and comparator done");
		v = $random(seed);
		FLASH_LOCK_ADDR <= {1'b0, v[15:0]};
		FLASH_ADDR <= {1'b0, v[15:0]};
		{FLASH_WRITE_ENABLE, FLASH_WRITE_ERASE, FLASH_CODE_READ, FLASH_FETCH} <= 4'hF;
		repeat (20) @(posedge CLK);
		chk("flash_ok", SYS_RESET, 0);
		for (int k = 0; k < 5; k++) begin
			v = $random(seed);
			FLASH_LOCK_ADDR <= {1'b0, v[15:0]};
			FLASH_ADDR <= {1'b0, v[15:0]} + (k < 3 ? 17'h1 + v[23:16] : 17'h0);
			{FLASH_WRITE_ENABLE, FLASH_WRITE_ERASE} <= {2{k == 0 || k == 4}};
			{FLASH_CODE_READ, FLASH_FETCH} <= {k == 1, k == 2};
			{FLASH_SECURITY_BLOCK, SUPPLY_MONITOR_ON} <= {k == 3, k != 4};
			trig(flag_of(rsc_pkg::FLASH_BIT), 5);
		end
		for (int k = 0; k < 2; k++) begin
			wr(CA, 32'h82);
			v = $random(seed);
			RTC_TIMER <= v;
			RTC_ALARM_VALUE <= v ^ 32'h1;
			RTC_ALARM_EN <= k == 0;
			repeat (20) @(posedge CLK);
			chk("rtc_idle", SYS_RESET, 0);
			RTC_ALARM_VALUE <= v;
			{RTC_CLKMON_EN, RTC_CLOCK_SLOW, SLEEP} <= {3{k == 1}};
			trig(flag_of(rsc_pkg::RTC_BIT), 5);
		end
		$display("test flash and rtc done");
		// Suspended time must not count towards the watchdog timeout
		SUSPEND <= 1;
		repeat (1500) @(posedge CLK);
		SUSPEND <= 0;
		repeat (2900) @(posedge CLK);
		chk("wdt_early", SYS_RESET, 0);
		trig(flag_of(rsc_pkg::WDT_BIT), 400);
		chk("wdt_time", lat > 120 && lat < 220, 1);
		$display("test watchdog done");
		wr(CT, 32'h0);
		wr(CA, 32'h06);
		SUSPEND <= 1;
		sense_run = 0;
		repeat (2200) @(posedge CLK);
		chk("mcd_asleep", SYS_RESET, 0);
		SUSPEND <= 0;
		trig(flag_of(rsc_pkg::MCD_BIT), 2300);
		chk("mcd_time", lat >= 1995 && lat <= 2010, 1);
		$display("test clock loss done");
		close_out();
	end
endmodule : rsc_top_tb
